/* verilog/apr_map.svh */
// Named constants for the serial remote-control packet interpreter
`ifndef APR_MAP_SVH
`define APR_MAP_SVH

// ----------------------------------------------------------------------
// Clock and character timing
// ----------------------------------------------------------------------
`define APR_CLK_HZ       50000000
`define APR_BAUD_MIN     1200
`define APR_BAUD_MAX     19200
`define APR_BAUD_SEL_MAX 3'h4
`define APR_STOP_IDX     4'h9
`define APR_DATA_LAST    4'h8

// ----------------------------------------------------------------------
// Packet characters
// ----------------------------------------------------------------------
`define APR_CH_CMD   8'h3c
`define APR_CH_RSP   8'h3e
`define APR_CH_DELIM 8'h2f
`define APR_CH_EQ    8'h3d
`define APR_CH_QRY   8'h3f
`define APR_CH_BANG  8'h21
`define APR_CH_STAR  8'h2a
`define APR_CH_CR    8'h0d
`define APR_CH_LF    8'h0a
`define APR_CH_ZERO  8'h30
`define APR_CH_NINE  8'h39
`define APR_CH_UPA   8'h41
`define APR_CH_UPZ   8'h5a
`define APR_CH_PRLO  8'h20
`define APR_CH_PRHI  8'h7e
`define APR_INS_ADDR 24'h535041

// ----------------------------------------------------------------------
// Packet positions and reset values
// ----------------------------------------------------------------------
`define APR_POS_DELIM 4'h4
`define APR_POS_QUAL  4'h8
`define APR_ARG_DIGS  3'h4
`define APR_ARG_SAT   3'h5
`define APR_LAST_DATA 4'hf
`define APR_LAST_BARE 4'hb
`define APR_ADDR_RST  16'h0001

`endif

/* verilog/apr_pkg.sv */
// Types shared by the remote-control packet interpreter
package apr_pkg;
    typedef enum logic [2:0] {
        ST_HUNT  = 3'h0,
        ST_HEAD  = 3'h1,
        ST_ARGS  = 3'h3,
        ST_CHECK = 3'h2,
        ST_SEND  = 3'h6,
        ST_WAIT  = 3'h7
    } apr_state_t;
endpackage

/* verilog/apr_uart.sv */
// Character receiver and transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ns
`include "apr_map.svh"
module apr_uart import apr_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bit period in clock cycles
    input  wire logic [15:0] bitCyc,
    // Serial lines
    input  wire logic       rxPin,
    output logic            txLine,
    // Byte side
    output logic            rxValid,
    output logic [7:0]      rxByte,
    input  wire logic       txGo,
    input  wire logic [7:0] txByte,
    output logic            txBusy
);
    logic        rxS1;
    logic        rxS2;
    logic        rxS3;
    logic        rxOn;
    logic [15:0] rxCnt;
    logic [3:0]  rxBit;
    logic [7:0]  rxShift;
    logic [15:0] txCnt;
    logic [3:0]  txBit;
    logic [8:0]  txShift;

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxS1 <= 1'b1;
            rxS2 <= 1'b1;
            rxS3 <= 1'b1;
        end else begin
            rxS1 <= rxPin;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
        end
    end

    // Samples at mid-bit; a start bit gone high again is taken as a glitch
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxOn    <= 1'b0;
            rxCnt   <= 16'h0000;
            rxBit   <= 4'h0;
            rxShift <= 8'h00;
            rxValid <= 1'b0;
            rxByte  <= 8'h00;
        end else begin
            rxValid <= 1'b0;
            if (!rxOn) begin
                if (rxS3 && !rxS2) begin
                    rxOn  <= 1'b1;
                    rxCnt <= bitCyc >> 1;
                    rxBit <= 4'h0;
                end
            end else if (rxCnt != 16'h0000) begin
                rxCnt <= rxCnt - 16'h0001;
            end else begin
                rxCnt <= bitCyc - 16'h0001;
                if (rxBit == 4'h0) begin
                    rxOn  <= !rxS2;
                    rxBit <= 4'h1;
                end else if (rxBit <= `APR_DATA_LAST) begin
                    rxShift <= {rxS2, rxShift[7:1]};
                    rxBit   <= rxBit + 4'h1;
                end else begin
                    rxOn <= 1'b0;
                    if (rxS2) begin
                        rxValid <= 1'b1;
                        rxByte  <= rxShift;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txBusy  <= 1'b0;
            txLine  <= 1'b1;
            txCnt   <= 16'h0000;
            txBit   <= 4'h0;
            txShift <= 9'h1ff;
        end else if (!txBusy) begin
            if (txGo) begin
                txBusy  <= 1'b1;
                txLine  <= 1'b0;
                txShift <= {1'b1, txByte};
                txCnt   <= bitCyc - 16'h0001;
                txBit   <= 4'h0;
            end
        end else if (txCnt != 16'h0000) begin
            txCnt <= txCnt - 16'h0001;
        end else begin
            txCnt <= bitCyc - 16'h0001;
            if (txBit == `APR_STOP_IDX) begin
                txBusy <= 1'b0;
            end else begin
                txLine  <= txShift[0];
                txShift <= {1'b1, txShift[8:1]};
                txBit   <= txBit + 4'h1;
            end
        end
    end

    tx_start_a: assert property (@(posedge clk) disable iff (!rstn)
        (!txBusy && txGo) |=> (!txLine && txBusy))
        else $error("Start bit not driven on byte load");
    tx_stop_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(txBusy) |-> (txLine && $past(txLine)))
        else $error("Stop bit not high at end of byte");
endmodule

/* verilog/apr_remote_ctrl.sv */
// Slave-side ASCII packet interpreter for a half-duplex serial link
// How it works
// - Characters use eight data bits, no parity, one stop bit.
// - Bit rate selectable from 1200 to 19200 baud.
// - Line driver enabled only while a reply is being sent.
// - Device transmits only in answer to a packet addressed to it.
// - Every addressed packet is answered; broadcast address zero gets none.
// - Reply: '>', four digits, '/', three letters, qualifier, optional args.
// - Start characters mark packet start only; '<' restarts parsing anywhere.
// - Unit address 1 to 9999, four digits, set by address command.
// - Reply carries the same address the command used.
// - Instruction letters are upper case only, case sensitive.
// - Only printable characters, CR and LF, appear in packets.
// - Reply ends with CR then LF.
// - Qualifier '=' ok, '?' bad argument, '*' valid but change disallowed.
// - Unrecognised instruction is echoed with '!'.
// - Arguments are digits only; a period, comma or other character marks them bad.
`timescale 1ns/1ns
`include "apr_map.svh"
module apr_remote_ctrl import apr_pkg::*; #(
    parameter int unsigned BIT_CYC_SLOW = `APR_CLK_HZ / `APR_BAUD_MIN
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Serial link
    input  wire logic       rxPin,
    output logic            txLine,
    output logic            txDrvEn,
    // Configuration pins
    input  wire logic [2:0] baudSel,
    input  wire logic       addrLock,
    // Status
    output logic [15:0]     unitAddr
);
    apr_state_t  st_reg;
    logic [3:0]  pos_reg;
    logic [3:0]  idx_reg;
    logic [15:0] rxAddr_reg;
    logic [23:0] ins_reg;
    logic [7:0]  qual_reg;
    logic [15:0] argBcd_reg;
    logic [2:0]  argCnt_reg;
    logic        argBad_reg;
    logic [7:0]  repQual_reg;
    logic        repData_reg;
    logic [2:0]  baudS1;
    logic [2:0]  baudS2;
    logic        lockS1;
    logic        lockS2;
    logic [15:0] bitCyc;
    logic        rxValid;
    logic [7:0]  rxByte;
    logic        txBusy;
    logic [7:0]  txByteSel;
    logic [7:0]  qualSel;
    logic        headOk;
    logic        isDigit;
    logic        isPrint;
    logic        known;
    logic        addrHit;
    logic        setOk;
    logic        dataSel;
    logic        doWrite;
    logic [3:0]  lastIdx;

    // ------------------------------------------------------------------
    // Pin synchronisers and bit timing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            baudS1 <= 3'h0;
            baudS2 <= 3'h0;
            lockS1 <= 1'b0;
            lockS2 <= 1'b0;
        end else begin
            baudS1 <= baudSel;
            baudS2 <= baudS1;
            lockS1 <= addrLock;
            lockS2 <= lockS1;
        end
    end

    // Rates are the slowest one doubled per step; larger codes clamp at the top rate
    always_comb begin
        if (baudS2 > `APR_BAUD_SEL_MAX) begin
            bitCyc = 16'(BIT_CYC_SLOW >> `APR_BAUD_SEL_MAX);
        end else begin
            bitCyc = 16'(BIT_CYC_SLOW >> baudS2);
        end
    end

    apr_uart uart (
        .clk     (clk),
        .rstn    (rstn),
        .bitCyc  (bitCyc),
        .rxPin   (rxPin),
        .txLine  (txLine),
        .rxValid (rxValid),
        .rxByte  (rxByte),
        .txGo    (st_reg == ST_SEND),
        .txByte  (txByteSel),
        .txBusy  (txBusy)
    );

    // ------------------------------------------------------------------
    // Character classes and command checks
    // ------------------------------------------------------------------
    always_comb begin
        isDigit = (rxByte >= `APR_CH_ZERO) && (rxByte <= `APR_CH_NINE);
        isPrint = ((rxByte >= `APR_CH_PRLO) && (rxByte <= `APR_CH_PRHI))
                  || (rxByte == `APR_CH_CR) || (rxByte == `APR_CH_LF);
        if (pos_reg < `APR_POS_DELIM) begin
            headOk = isDigit;
        end else if (pos_reg == `APR_POS_DELIM) begin
            headOk = rxByte == `APR_CH_DELIM;
        end else if (pos_reg < `APR_POS_QUAL) begin
            headOk = (rxByte >= `APR_CH_UPA) && (rxByte <= `APR_CH_UPZ);
        end else begin
            headOk = (rxByte == `APR_CH_EQ) || (rxByte == `APR_CH_QRY);
        end
    end

    assign known   = ins_reg == `APR_INS_ADDR;
    assign addrHit = rxAddr_reg == unitAddr;
    assign setOk   = (argCnt_reg == `APR_ARG_DIGS) && !argBad_reg
                     && (argBcd_reg != 16'h0000);
    assign dataSel = known && (qual_reg == `APR_CH_QRY) && (argCnt_reg == 3'h0)
                     && !argBad_reg;
    assign doWrite = (st_reg == ST_CHECK) && (addrHit || rxAddr_reg == 16'h0000)
                     && known && (qual_reg == `APR_CH_EQ) && setOk && !lockS2;
    assign lastIdx = repData_reg ? `APR_LAST_DATA : `APR_LAST_BARE;

    always_comb begin
        if (!known) begin
            qualSel = `APR_CH_BANG;
        end else if (qual_reg == `APR_CH_QRY) begin
            qualSel = dataSel ? `APR_CH_EQ : `APR_CH_QRY;
        end else if (!setOk) begin
            qualSel = `APR_CH_QRY;
        end else if (lockS2) begin
            qualSel = `APR_CH_STAR;
        end else begin
            qualSel = `APR_CH_EQ;
        end
    end

    // ------------------------------------------------------------------
    // Packet sequencer
    // ------------------------------------------------------------------
    // Receive is ignored while replying: on a two-wire bus it hears its own echo
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg  <= ST_HUNT;
            pos_reg <= 4'h0;
            idx_reg <= 4'h0;
        end else begin
            case (st_reg)
                ST_HUNT: begin
                    if (rxValid && rxByte == `APR_CH_CMD) begin
                        st_reg  <= ST_HEAD;
                        pos_reg <= 4'h0;
                    end
                end
                ST_HEAD: begin
                    if (rxValid) begin
                        if (rxByte == `APR_CH_CMD) begin
                            pos_reg <= 4'h0;
                        end else if (!headOk) begin
                            st_reg <= ST_HUNT;
                        end else if (pos_reg == `APR_POS_QUAL) begin
                            st_reg <= ST_ARGS;
                        end else begin
                            pos_reg <= pos_reg + 4'h1;
                        end
                    end
                end
                ST_ARGS: begin
                    if (rxValid) begin
                        if (rxByte == `APR_CH_CMD) begin
                            st_reg  <= ST_HEAD;
                            pos_reg <= 4'h0;
                        end else if (rxByte == `APR_CH_CR) begin
                            st_reg <= ST_CHECK;
                        end else if (!isPrint || rxByte == `APR_CH_RSP
                                     || rxByte == `APR_CH_LF) begin
                            st_reg <= ST_HUNT;
                        end
                    end
                end
                ST_CHECK: begin
                    idx_reg <= 4'h0;
                    st_reg  <= addrHit ? ST_SEND : ST_HUNT;
                end
                ST_SEND: begin
                    st_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!txBusy) begin
                        if (idx_reg == lastIdx) begin
                            st_reg <= ST_HUNT;
                        end else begin
                            idx_reg <= idx_reg + 4'h1;
                            st_reg  <= ST_SEND;
                        end
                    end
                end
                default: begin
                    st_reg <= ST_HUNT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Field capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxAddr_reg  <= 16'h0000;
            ins_reg     <= 24'h000000;
            qual_reg    <= 8'h00;
            argBcd_reg  <= 16'h0000;
            argCnt_reg  <= 3'h0;
            argBad_reg  <= 1'b0;
            repQual_reg <= 8'h00;
            repData_reg <= 1'b0;
        end else begin
            if (st_reg == ST_HEAD && rxValid && headOk) begin
                if (pos_reg < `APR_POS_DELIM) begin
                    rxAddr_reg <= {rxAddr_reg[11:0], rxByte[3:0]};
                end else if (pos_reg < `APR_POS_QUAL && pos_reg != `APR_POS_DELIM) begin
                    ins_reg <= {ins_reg[15:0], rxByte};
                end else if (pos_reg == `APR_POS_QUAL) begin
                    qual_reg   <= rxByte;
                    argBcd_reg <= 16'h0000;
                    argCnt_reg <= 3'h0;
                    argBad_reg <= 1'b0;
                end
            end
            if (st_reg == ST_ARGS && rxValid && rxByte != `APR_CH_CR) begin
                if (isDigit) begin
                    argBcd_reg <= {argBcd_reg[11:0], rxByte[3:0]};
                    if (argCnt_reg != `APR_ARG_SAT) begin
                        argCnt_reg <= argCnt_reg + 3'h1;
                    end
                end else begin
                    argBad_reg <= 1'b1;
                end
            end
            if (st_reg == ST_CHECK) begin
                repQual_reg <= qualSel;
                repData_reg <= dataSel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Unit address and line driver
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            unitAddr <= `APR_ADDR_RST;
        end else if (doWrite) begin
            unitAddr <= argBcd_reg;
        end
    end

    // Raised on the edge the start bit goes out, dropped after the last stop bit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txDrvEn <= 1'b0;
        end else begin
            txDrvEn <= (st_reg == ST_SEND) || (st_reg == ST_WAIT);
        end
    end

    // ------------------------------------------------------------------
    // Reply bytes
    // ------------------------------------------------------------------
    always_comb begin
        if (idx_reg == lastIdx) begin
            txByteSel = `APR_CH_LF;
        end else if (idx_reg == lastIdx - 4'h1) begin
            txByteSel = `APR_CH_CR;
        end else begin
            case (idx_reg)
                4'h0:    txByteSel = `APR_CH_RSP;
                4'h1:    txByteSel = `APR_CH_ZERO | {4'h0, rxAddr_reg[15:12]};
                4'h2:    txByteSel = `APR_CH_ZERO | {4'h0, rxAddr_reg[11:8]};
                4'h3:    txByteSel = `APR_CH_ZERO | {4'h0, rxAddr_reg[7:4]};
                4'h4:    txByteSel = `APR_CH_ZERO | {4'h0, rxAddr_reg[3:0]};
                4'h5:    txByteSel = `APR_CH_DELIM;
                4'h6:    txByteSel = ins_reg[23:16];
                4'h7:    txByteSel = ins_reg[15:8];
                4'h8:    txByteSel = ins_reg[7:0];
                4'h9:    txByteSel = repQual_reg;
                4'ha:    txByteSel = `APR_CH_ZERO | {4'h0, unitAddr[15:12]};
                4'hb:    txByteSel = `APR_CH_ZERO | {4'h0, unitAddr[11:8]};
                4'hc:    txByteSel = `APR_CH_ZERO | {4'h0, unitAddr[7:4]};
                4'hd:    txByteSel = `APR_CH_ZERO | {4'h0, unitAddr[3:0]};
                default: txByteSel = `APR_CH_CR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    drv_idle_a: assert property (!txDrvEn |-> txLine)
        else $error("Line not idle with driver off");
    reply_cause_a: assert property ($rose(txDrvEn) |-> $past(st_reg, 2) == ST_CHECK)
        else $error("Reply began without a checked command");
    bcast_quiet_a: assert property ((st_reg == ST_CHECK && rxAddr_reg == 16'h0000)
        |=> st_reg == ST_HUNT ##1 !txDrvEn)
        else $error("Reply to broadcast packet");
    foreign_quiet_a: assert property ((st_reg == ST_CHECK && !addrHit)
        |=> st_reg == ST_HUNT)
        else $error("Reply to packet for another unit");
    reply_start_a: assert property ((st_reg == ST_SEND && idx_reg == 4'h0)
        |-> txByteSel == `APR_CH_RSP)
        else $error("Reply does not open with start character");
    addr_echo_a: assert property ((st_reg == ST_SEND && idx_reg == 4'h1)
        |-> txByteSel[3:0] == rxAddr_reg[15:12])
        else $error("Reply address differs from command");
    addr_write_a: assert property (doWrite |=> unitAddr == $past(argBcd_reg))
        else $error("Address write not applied");
    addr_range_a: assert property (unitAddr != 16'h0000)
        else $error("Unit address became zero");
    unknown_bang_a: assert property ((st_reg == ST_CHECK && !known)
        |=> repQual_reg == `APR_CH_BANG)
        else $error("Unknown instruction not flagged");
    lock_star_a: assert property ((st_reg == ST_CHECK && known && qual_reg == `APR_CH_EQ
        && setOk && lockS2) |=> repQual_reg == `APR_CH_STAR)
        else $error("Disallowed change not flagged");
    reply_end_a: assert property ((st_reg == ST_SEND && idx_reg == lastIdx)
        |-> txByteSel == `APR_CH_LF && $past(txByteSel, 1) != `APR_CH_LF)
        else $error("Reply does not end with line feed");
endmodule

/* bench/apr_master.sv */
// Serial bus master model: sends command bytes and decodes reply bytes
`timescale 1ns/1ns
module apr_master (
    // Clock and bit period
    input  wire logic        clk,
    input  wire logic [15:0] bitCyc,
    // Serial link
    output logic             rxPin,
    input  wire logic        txLine,
    input  wire logic        txDrvEn,
    // Decoded reply bytes
    output logic             gotByte,
    output logic [7:0]       rspByte
);
    logic       line;
    logic [7:0] b;

    // Fail-safe bias holds the released bus high
    assign line = txDrvEn ? txLine : 1'b1;

    initial begin
        rxPin = 1'b1;
        gotByte = 1'b0;
        rspByte = 8'h00;
    end

    // Start bit, eight data bits LSB first, one stop bit, no parity
    task automatic sendByte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rxPin = f[i];
            repeat (bitCyc - 1) @(negedge clk);
        end
    endtask

    // A bad stop bit turns the byte into 00 so it cannot match
    initial forever begin
        @(negedge clk);
        gotByte = 1'b0;
        if (line === 1'b0) begin
            repeat (bitCyc / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bitCyc) @(negedge clk);
                b[i] = line;
            end
            repeat (bitCyc) @(negedge clk);
            rspByte = (line === 1'b1) ? b : 8'h00;
            gotByte = 1'b1;
        end
    end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the packet interpreter
`timescale 1ns/1ns
module tb_top;
    logic        clk, rstn, rxPin, txLine, txDrvEn, addrLock, gotByte;
    logic [2:0]  baudSel;
    logic [15:0] unitAddr, bitCyc;
    logic [7:0]  rspByte;
    logic [7:0]  expQ[$];
    logic [31:0] seed = 32'h00016cfe;
    logic [15:0] dv;
    logic [3:0]  dg;
    int          num_errors = 0;
    int          tests_run = 0;
    string       d, f, ins;

    assign bitCyc = 16'h0020 >> baudSel;

    apr_remote_ctrl #(.BIT_CYC_SLOW(32)) DUT (.clk(clk), .rstn(rstn), .rxPin(rxPin),
        .txLine(txLine), .txDrvEn(txDrvEn), .baudSel(baudSel), .addrLock(addrLock),
        .unitAddr(unitAddr));
    apr_master mst (.clk(clk), .bitCyc(bitCyc), .rxPin(rxPin), .txLine(txLine),
        .txDrvEn(txDrvEn), .gotByte(gotByte), .rspByte(rspByte));

    // ----------------------------------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        summarize();
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d compares=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bytes of a string, in order, through the master model
    task automatic sendStr(input string s);
        for (int i = 0; i < s.len(); i++) mst.sendByte(s[i]);
    endtask

    // Queue the reply first, then send; an empty reply means silence
    task automatic cmd(input string a, input string b, input string r);
        string e;
        e = (r.len() > 0) ? {">", a, "/", r, "\r\n"} : "";
        for (int i = 0; i < e.len(); i++) expQ.push_back(e[i]);
        sendStr({"<", a, "/", b, "\r"});
        for (int k = 0; k < 8000 && expQ.size() > 0; k++) @(negedge clk);
        repeat (20 * bitCyc) @(negedge clk);
        check(16'(expQ.size()), 16'h0000);
        check({15'h0000, txDrvEn}, 16'h0000);
    endtask

    // Any byte with nothing queued is an unsolicited transmission
    always @(posedge clk) begin
        if (gotByte === 1'b1) begin
            if (expQ.size() == 0)
                check({8'h00, rspByte}, 16'h0100);
            else
                check({8'h00, rspByte}, {8'h00, expQ.pop_front()});
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        baudSel = 3'h0;
        addrLock = 1'b0;
        // Letters of the address-setting instruction
        ins = $sformatf("%c%c%c", 8'h53, 8'h50, 8'h41);
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check(unitAddr, 16'h0001);
        for (int s = 0; s < 2; s++) begin
            baudSel = 3'(s);
            cmd("0001", {ins, "?"}, {ins, "=0001"});
        end
        d = "0000";
        dv = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            dg = 4'(seed % ((i == 0) ? 9 : 10)) + ((i == 0) ? 4'h1 : 4'h0);
            d[i] = {4'h3, dg};
            dv = {dv[11:0], dg};
        end
        cmd("0001", {ins, "=", d}, {ins, "="});
        check(unitAddr, dv);
        cmd(d, "XYZ?", "XYZ!");
        cmd(d, {ins, "=12"}, {ins, "?"});
        cmd(d, {ins, "=1.34"}, {ins, "?"});
        addrLock = 1'b1;
        cmd(d, {ins, "=0077"}, {ins, "*"});
        check(unitAddr, dv);
        addrLock = 1'b0;
        f = d;
        f[3] = (d[3] == 8'h35) ? 8'h36 : 8'h35;
        cmd(f, {ins, "?"}, "");
        cmd(d, {ins.tolower(), "?"}, "");
        sendStr("<12");
        cmd(d, {ins, "?"}, {ins, "=", d});
        cmd("0000", {ins, "=0042"}, "");
        check(unitAddr, 16'h0042);
        cmd("0042", {ins, "?"}, {ins, "=0042"});
        summarize();
    end
endmodule
